/* File: inc/gvc_params.svh */
// Register offsets, field positions, reset values and link constants.
`ifndef GVC_PARAMS_SVH
`define GVC_PARAMS_SVH

`define GVC_I2C_ADDR  7'h10
`define GVC_REG_REV   8'h00
`define GVC_REG_VMODE 8'h01
`define GVC_REG_LINK  8'h02
`define GVC_REG_LIDX  8'h03
`define GVC_REG_LHI   8'h04
`define GVC_REG_LLO   8'h05

`define GVC_VM_ILACE  2
`define GVC_VM_VPOL   1
`define GVC_VM_HPOL   0
`define GVC_LK_PRBS   2
`define GVC_LK_ALIGN  1
`define GVC_LK_SKEW   0

`define GVC_VM_RST    8'h00
`define GVC_LK_RST    8'h00
// Revision value is arbitrary.
`define GVC_REV_VAL   3'h5

`define GVC_LUT_DEPTH 256
`define GVC_PRBS_SEED 7'h7f
`define GVC_ALIGN_PAT 8'hf0

`endif

/* File: inc/gvc_pkg.sv */
// Types shared by the gamma video controller modules.
package gvc_pkg;
    typedef logic [9:0] gvc_word_t;
    typedef logic [7:0] gvc_idx_t;
    typedef enum logic [3:0] {
        GVC_IDLE, GVC_ADDR, GVC_AACK, GVC_PTR, GVC_PACK,
        GVC_WDAT, GVC_WACK, GVC_RDAT, GVC_RACK
    } gvc_i2c_e;

    function automatic gvc_word_t gvc_gray(input gvc_word_t w);
        return w ^ (w >> 1);
    endfunction
endpackage

/* File: inc/gvc_lut_if.sv */
// Table write, read-back and pixel lookup signals between top and table.
`timescale 1ns/1ps
interface gvc_lut_if;
    logic                     wr_en;
    gvc_pkg::gvc_idx_t        wr_idx;
    gvc_pkg::gvc_word_t       wr_data;
    gvc_pkg::gvc_idx_t        rd_idx;
    gvc_pkg::gvc_word_t       rd_data;
    gvc_pkg::gvc_idx_t        pix_in  [3];
    gvc_pkg::gvc_word_t       pix_out [3];

    modport user  (output wr_en, wr_idx, wr_data, rd_idx, pix_in,
                   input  rd_data, pix_out);
    modport store (input  wr_en, wr_idx, wr_data, rd_idx, pix_in,
                   output rd_data, pix_out);
endinterface

/* File: rtl/gvc_lut.sv */
// Gamma table storage with read-back port and three gray-coded lookups.
`timescale 1ns/1ps
`include "gvc_params.svh"
module gvc_lut (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic arst_n,
    // Table access
    gvc_lut_if.store  lut
);
    gvc_pkg::gvc_word_t mem      [`GVC_LUT_DEPTH];
    gvc_pkg::gvc_word_t next_mem [`GVC_LUT_DEPTH];
    gvc_pkg::gvc_word_t next_out [3];

    // Entries hold plain values; read-back sees them before gray coding.
    assign lut.rd_data = mem[lut.rd_idx];

    for (genvar e = 0; e < `GVC_LUT_DEPTH; e++) begin : g_ent
        always_comb begin
            next_mem[e] = mem[e];
            if (lut.wr_en && lut.wr_idx == 8'(e)) begin
                next_mem[e] = lut.wr_data;
            end
        end
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                mem[e] <= 10'h000;
            end else begin
                mem[e] <= next_mem[e];
            end
        end
    end

    // One table serves all three colours.
    for (genvar c = 0; c < 3; c++) begin : g_chan
        always_comb begin
            next_out[c] = gvc_pkg::gvc_gray(mem[lut.pix_in[c]]);
        end
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                lut.pix_out[c] <= 10'h000;
            end else begin
                lut.pix_out[c] <= next_out[c];
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    lut_store_a: assert property (lut.wr_en |=>
        mem[$past(lut.wr_idx)] == $past(lut.wr_data))
        else $error("table entry not stored");
    gray_out_a: assert property (##1 lut.pix_out[0] ==
        gvc_pkg::gvc_gray($past(mem[lut.pix_in[0]])))
        else $error("red output not gray of table entry");
    same_curve_a: assert property (
        lut.pix_in[1] == lut.pix_in[2] |=> lut.pix_out[1] == lut.pix_out[2])
        else $error("channels use different curves");
endmodule

/* File: rtl/gvc_link.sv */
// Serial link lane patterns: normal data, PRBS, align and skew modes.
`timescale 1ns/1ps
`include "gvc_params.svh"
module gvc_link (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // Control
    input  wire logic       px_edge,
    input  wire logic       pattern_test_enable,
    input  wire logic       align_mode_enable,
    input  wire logic       skew_comp_enable,
    input  wire logic       align_req,
    input  wire logic [4:0] norm,
    // Lanes
    output logic      [4:0] serial_data_pair,
    output logic            serial_clk
);
    logic [6:0] prbs;
    logic [7:0] apat;
    logic       skw;
    logic [6:0] next_prbs;
    logic [7:0] next_apat;
    logic       next_skw;
    logic [4:0] next_lane;
    logic       next_clk;

    always_comb begin
        next_prbs = prbs;
        next_apat = apat;
        next_skw  = skw;
        next_lane = serial_data_pair;
        next_clk  = serial_clk;
        if (px_edge) begin
            next_prbs = {prbs[5:0], prbs[6] ^ prbs[5]};
            next_apat = {apat[6:0], apat[7]};
            next_skw  = ~skw;
            next_clk  = ~serial_clk;
            next_lane = norm;
            if (pattern_test_enable) begin
                next_lane[4] = prbs[6];
            end
            if (align_mode_enable && align_req) begin
                next_lane[2] = apat[7];
            end
            // Skew training overrides the other test patterns on all lanes.
            if (skew_comp_enable) begin
                next_lane = {5{skw}};
                next_clk  = ~skw;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prbs             <= `GVC_PRBS_SEED;
            apat             <= `GVC_ALIGN_PAT;
            skw              <= 1'b0;
            serial_data_pair <= 5'h00;
            serial_clk       <= 1'b0;
        end else begin
            prbs             <= next_prbs;
            apat             <= next_apat;
            skw              <= next_skw;
            serial_data_pair <= next_lane;
            serial_clk       <= next_clk;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    prbs_lane_a: assert property (
        px_edge && pattern_test_enable && !skew_comp_enable
        |=> serial_data_pair[4] == $past(prbs[6]))
        else $error("PRBS lane wrong");
    align_lane_a: assert property (
        px_edge && align_mode_enable && align_req && !skew_comp_enable
        |=> serial_data_pair[2] == $past(apat[7]))
        else $error("align lane wrong");
    skew_lanes_a: assert property (
        px_edge && skew_comp_enable
        |=> serial_data_pair == {5{$past(skw)}} && serial_clk != $past(skw))
        else $error("skew pattern wrong");
    normal_lane_a: assert property (
        px_edge && !pattern_test_enable && !align_mode_enable
        && !skew_comp_enable |=> serial_data_pair == $past(norm))
        else $error("normal lanes wrong");
endmodule

/* File: rtl/gvc_top.sv */
// Gamma video controller: I2C register slave, gamma table and video out.
// Contract
// - Each input pixel value is mapped through a 256-entry table.
// - Table holds plain values; gray coding follows; read-back is plain.
// - All 256 table entries can be read back by the master.
// - Interlace bit set drives generated field onto the enable pin.
// - Video mode bit 1 selects vertical sync polarity, 1 is positive.
// - Video mode bit 0 selects horizontal sync polarity, 1 is positive.
// - Link control bit 2 sends PRBS on serial lane 4.
// - Link control bit 1 sends align data on lane 2 while pin high.
// - Link control bit 0 sends skew compensation data and clock patterns.
// - Red, green and blue use the same gamma curve.
`timescale 1ns/1ps
`include "gvc_params.svh"
module gvc_top (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // I2C slave pins
    input  wire logic       scl,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Video input
    input  wire logic       pix_clk,
    input  wire logic [7:0] pix_r,
    input  wire logic [7:0] pix_g,
    input  wire logic [7:0] pix_b,
    input  wire logic       pix_hs,
    input  wire logic       pix_vs,
    input  wire logic       pix_de,
    input  wire logic       align_request_pin,
    // Display output
    output logic      [9:0] disp_r,
    output logic      [9:0] disp_g,
    output logic      [9:0] disp_b,
    output logic            disp_hs,
    output logic            disp_vs,
    output logic            disp_enable,
    // Serial link
    output logic      [4:0] serial_data_pair,
    output logic            serial_clk
);
    localparam int SW = 31;

    gvc_lut_if lut ();

    // Two-stage synchroniser for every pin input; only s2 is read.
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [2:0]    e3;
    logic          scl_s;
    logic          sda_s;
    logic          pclk_s;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= '0;
            s2 <= '0;
            e3 <= 3'h0;
        end else begin
            s1 <= {scl, sda_i, pix_clk, pix_hs, pix_vs, pix_de,
                   align_request_pin, pix_r, pix_g, pix_b};
            s2 <= s1;
            e3 <= s2[SW-1:SW-3];
        end
    end

    assign scl_s  = s2[SW-1];
    assign sda_s  = s2[SW-2];
    assign pclk_s = s2[SW-3];

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic px_edge;

    assign scl_rise  = scl_s & ~e3[2];
    assign scl_fall  = ~scl_s & e3[2];
    assign start_det = scl_s & e3[2] & ~sda_s & e3[1];
    assign stop_det  = scl_s & e3[2] & sda_s & ~e3[1];
    assign px_edge   = pclk_s & ~e3[0];

    // I2C slave state.
    gvc_pkg::gvc_i2c_e st;
    gvc_pkg::gvc_i2c_e next_st;
    logic [3:0] bits;
    logic [3:0] next_bits;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic       rw;
    logic       next_rw;
    logic       drv;
    logic       next_drv;
    logic [7:0] video_mode_ctrl;
    logic [7:0] next_vmode;
    logic [7:0] serial_link_ctrl;
    logic [7:0] next_link;
    logic [7:0] lidx;
    logic [7:0] next_lidx;
    logic [1:0] hi;
    logic [1:0] next_hi;
    logic       do_load;
    logic [7:0] rd_byte;
    logic [7:0] ptr_adv;

    // Reading the low table byte steps the index so a burst walks the table.
    always_comb begin
        unique case (ptr)
            `GVC_REG_REV:   rd_byte = {5'h00, `GVC_REV_VAL};
            `GVC_REG_VMODE: rd_byte = video_mode_ctrl;
            `GVC_REG_LINK:  rd_byte = serial_link_ctrl;
            `GVC_REG_LIDX:  rd_byte = lidx;
            `GVC_REG_LHI:   rd_byte = {6'h00, lut.rd_data[9:8]};
            `GVC_REG_LLO:   rd_byte = lut.rd_data[7:0];
            default:        rd_byte = 8'h00;
        endcase
        ptr_adv = (ptr == `GVC_REG_LLO) ? `GVC_REG_LHI : 8'(ptr + 8'h01);
    end

    always_comb begin
        next_st    = st;
        next_bits  = bits;
        next_sh    = sh;
        next_ptr   = ptr;
        next_rw    = rw;
        next_drv   = drv;
        next_vmode = video_mode_ctrl;
        next_link  = serial_link_ctrl;
        next_lidx  = lidx;
        next_hi    = hi;
        lut.wr_en  = 1'b0;
        do_load    = 1'b0;
        if (stop_det) begin
            next_st  = gvc_pkg::GVC_IDLE;
            next_drv = 1'b0;
        end else if (start_det) begin
            next_st   = gvc_pkg::GVC_ADDR;
            next_bits = 4'h0;
            next_drv  = 1'b0;
        end else begin
            unique case (st)
                gvc_pkg::GVC_IDLE: begin
                end
                gvc_pkg::GVC_ADDR, gvc_pkg::GVC_PTR, gvc_pkg::GVC_WDAT: begin
                    if (scl_rise && bits != 4'h8) begin
                        next_sh   = {sh[6:0], sda_s};
                        next_bits = 4'(bits + 4'h1);
                    end else if (scl_fall && bits == 4'h8) begin
                        next_bits = 4'h0;
                        next_drv  = 1'b1;
                        if (st == gvc_pkg::GVC_ADDR) begin
                            next_rw = sh[0];
                            next_st = gvc_pkg::GVC_AACK;
                            if (sh[7:1] != `GVC_I2C_ADDR) begin
                                next_drv = 1'b0;
                                next_st  = gvc_pkg::GVC_IDLE;
                            end
                        end else if (st == gvc_pkg::GVC_PTR) begin
                            next_ptr = sh;
                            next_st  = gvc_pkg::GVC_PACK;
                        end else begin
                            next_st  = gvc_pkg::GVC_WACK;
                            next_ptr = ptr_adv;
                            unique case (ptr)
                                `GVC_REG_VMODE: next_vmode = sh;
                                `GVC_REG_LINK:  next_link  = sh;
                                `GVC_REG_LIDX:  next_lidx  = sh;
                                `GVC_REG_LHI:   next_hi    = sh[1:0];
                                `GVC_REG_LLO: begin
                                    lut.wr_en = 1'b1;
                                    next_lidx = 8'(lidx + 8'h01);
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                gvc_pkg::GVC_AACK: begin
                    if (scl_fall) begin
                        next_drv = 1'b0;
                        next_st  = gvc_pkg::GVC_PTR;
                        do_load  = rw;
                    end
                end
                gvc_pkg::GVC_PACK, gvc_pkg::GVC_WACK: begin
                    if (scl_fall) begin
                        next_drv = 1'b0;
                        next_st  = gvc_pkg::GVC_WDAT;
                    end
                end
                gvc_pkg::GVC_RDAT: begin
                    if (scl_fall && bits == 4'h8) begin
                        next_drv  = 1'b0;
                        next_bits = 4'h0;
                        next_st   = gvc_pkg::GVC_RACK;
                    end else if (scl_fall) begin
                        next_sh   = {sh[6:0], 1'b0};
                        next_drv  = ~sh[6];
                        next_bits = 4'(bits + 4'h1);
                    end
                end
                gvc_pkg::GVC_RACK: begin
                    if (scl_rise && sda_s) begin
                        next_st = gvc_pkg::GVC_IDLE;
                    end else if (scl_rise) begin
                        next_bits = 4'h1;
                    end else if (scl_fall && bits == 4'h1) begin
                        do_load = 1'b1;
                    end
                end
            endcase
            if (do_load) begin
                next_sh   = rd_byte;
                next_drv  = ~rd_byte[7];
                next_bits = 4'h1;
                next_st   = gvc_pkg::GVC_RDAT;
                next_ptr  = ptr_adv;
                if (ptr == `GVC_REG_LLO) begin
                    next_lidx = 8'(lidx + 8'h01);
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st               <= gvc_pkg::GVC_IDLE;
            bits             <= 4'h0;
            sh               <= 8'h00;
            ptr              <= 8'h00;
            rw               <= 1'b0;
            drv              <= 1'b0;
            video_mode_ctrl  <= `GVC_VM_RST;
            serial_link_ctrl <= `GVC_LK_RST;
            lidx             <= 8'h00;
            hi               <= 2'h0;
        end else begin
            st               <= next_st;
            bits             <= next_bits;
            sh               <= next_sh;
            ptr              <= next_ptr;
            rw               <= next_rw;
            drv              <= next_drv;
            video_mode_ctrl  <= next_vmode;
            serial_link_ctrl <= next_link;
            lidx             <= next_lidx;
            hi               <= next_hi;
        end
    end

    // Open drain: the pin is only ever pulled low.
    assign sda_o       = 1'b0;
    assign sda_oe      = drv;
    assign lut.wr_idx  = lidx;
    assign lut.wr_data = {hi, sh};
    assign lut.rd_idx  = lidx;

    // Pixel path: capture on pixel clock edge, table stage, then output.
    logic ilace;
    logic hs_in;
    logic vs_in;
    logic de_in;
    logic hs1;
    logic vs1;
    logic de1;
    logic field;
    logic next_hs1;
    logic next_vs1;
    logic next_de1;
    logic next_field;
    gvc_pkg::gvc_idx_t next_pix [3];

    assign ilace = video_mode_ctrl[`GVC_VM_ILACE];
    assign hs_in = s2[SW-4];
    assign vs_in = s2[SW-5];
    assign de_in = s2[SW-6];

    always_comb begin
        next_hs1   = hs1;
        next_vs1   = vs1;
        next_de1   = de1;
        next_field = field;
        next_pix   = lut.pix_in;
        if (px_edge) begin
            next_hs1 = hs_in ~^ video_mode_ctrl[`GVC_VM_HPOL];
            next_vs1 = vs_in ~^ video_mode_ctrl[`GVC_VM_VPOL];
            next_de1 = de_in;
            next_pix = '{s2[23:16], s2[15:8], s2[7:0]};
            if (next_vs1 && !vs1) begin
                next_field = ~field;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hs1         <= 1'b0;
            vs1         <= 1'b0;
            de1         <= 1'b0;
            field       <= 1'b0;
            lut.pix_in  <= '{8'h00, 8'h00, 8'h00};
            disp_hs     <= 1'b0;
            disp_vs     <= 1'b0;
            disp_enable <= 1'b0;
        end else begin
            hs1         <= next_hs1;
            vs1         <= next_vs1;
            de1         <= next_de1;
            field       <= next_field;
            lut.pix_in  <= next_pix;
            disp_hs     <= hs1;
            disp_vs     <= vs1;
            disp_enable <= ilace ? field : de1;
        end
    end

    assign disp_r = lut.pix_out[0];
    assign disp_g = lut.pix_out[1];
    assign disp_b = lut.pix_out[2];

    gvc_lut u_lut (
        .mclk   (mclk),
        .arst_n (arst_n),
        .lut    (lut.store)
    );

    gvc_link u_link (
        .mclk                (mclk),
        .arst_n              (arst_n),
        .px_edge             (px_edge),
        .pattern_test_enable (serial_link_ctrl[`GVC_LK_PRBS]),
        .align_mode_enable   (serial_link_ctrl[`GVC_LK_ALIGN]),
        .skew_comp_enable    (serial_link_ctrl[`GVC_LK_SKEW]),
        .align_req           (s2[SW-7]),
        .norm                ({de1, vs1, hs1, field, ilace}),
        .serial_data_pair    (serial_data_pair),
        .serial_clk          (serial_clk)
    );

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    enable_route_a: assert property (
        ##1 disp_enable == $past(ilace ? field : de1))
        else $error("enable pin source wrong");
    hsync_pol_a: assert property (px_edge |-> ##2
        disp_hs == ($past(hs_in, 2) ~^ $past(video_mode_ctrl[0], 2)))
        else $error("horizontal sync polarity wrong");
    vsync_pol_a: assert property (px_edge |-> ##2
        disp_vs == ($past(vs_in, 2) ~^ $past(video_mode_ctrl[1], 2)))
        else $error("vertical sync polarity wrong");
    lut_readback_a: assert property (
        do_load && ptr == `GVC_REG_LLO |=> sh == $past(lut.rd_data[7:0])
        && lidx == 8'($past(lidx) + 8'h01))
        else $error("table read-back byte wrong");
    lut_commit_a: assert property (
        lut.wr_en |=> lidx == 8'($past(lidx) + 8'h01) && ptr == `GVC_REG_LHI)
        else $error("table write did not advance");

    ilace_cov: cover property (ilace && px_edge ##[1:40] disp_enable);
    read_cov: cover property (do_load && ptr == `GVC_REG_LLO);
    write_cov: cover property (lut.wr_en);
endmodule

/* File: test/gvc_i2c_master.sv */
// Two-wire bus master model of the board controller.
`timescale 1ns/1ps
module gvc_i2c_master (
    // Clock
    input  wire logic mclk,
    // Bus
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe
);
    logic [7:0] rd_byte;
    event       got;

    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // A quarter bit of 13 cycles keeps the bus just under 400 kHz.
    task automatic q;
        repeat (13) @(negedge mclk);
    endtask
    task automatic start;
        sda_oe = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_oe = 1'b1;
        q;
        scl = 1'b0;
        q;
    endtask
    task automatic stop;
        sda_oe = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_oe = 1'b0;
        q;
    endtask
    task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_oe = ~d[i];
            q;
            scl = 1'b1;
            q;
            r[i] = sda;
            q;
            scl = 1'b0;
            q;
        end
        sda_oe = 1'b0;
    endtask
    task automatic rbyte(input logic last);
        logic [8:0] r;
        xbyte({8'hff, last}, r);
        rd_byte = r[8:1];
        -> got;
    endtask
endmodule

/* File: test/gvc_top_tb.sv */
// Self-checking bench for the gamma video controller top.
`timescale 1ns/1ps
`include "gvc_params.svh"
`define CHK(nm, e, s) \
    begin \
        comparisons++; \
        if ((s) !== (e)) begin \
            $display("mismatch %s expected %h seen %h", nm, e, s); \
            err_count++; \
        end \
    end
module gvc_top_tb;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        pix_clk = 1'b0;
    logic        scl, sda, m_oe, sda_oe, hs, vs, de, align, skew_on;
    logic        fld, pv;
    logic [7:0]  pr, pg, pb, e8;
    logic [9:0]  dr, dg, db, v, lut [256];
    logic        dhs, dvs, den, ser_clk;
    logic [4:0]  lanes;
    logic [8:0]  r9;
    logic [32:0] e33;
    logic [7:0]  rd_q [$];
    logic [7:0]  d [$];
    logic [32:0] px_q [$];
    int          err_count, comparisons, seed, c;

    always #25 mclk = ~mclk;
    // The pixel clock is offset so its edges fall 12 ns after an mclk rising edge.
    initial #37 forever #200 pix_clk = ~pix_clk;
    assign sda = ~(m_oe | sda_oe);

    gvc_i2c_master m_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_oe(m_oe));
    gvc_top dut_u (.mclk(mclk), .arst_n(arst_n), .scl(scl), .sda_i(sda),
        .sda_o(), .sda_oe(sda_oe), .pix_clk(pix_clk), .pix_r(pr),
        .pix_g(pg), .pix_b(pb), .pix_hs(hs), .pix_vs(vs), .pix_de(de),
        .align_request_pin(align), .disp_r(dr), .disp_g(dg), .disp_b(db),
        .disp_hs(dhs), .disp_vs(dvs), .disp_enable(den),
        .serial_data_pair(lanes), .serial_clk(ser_clk));

    function automatic logic [9:0] gr(input logic [7:0] i);
        return lut[i] ^ (lut[i] >> 1);
    endfunction
    task automatic end_sim;
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wbyte(input logic [7:0] b);
        logic [8:0] r;
        m_u.xbyte({b, 1'b1}, r);
        `CHK("ack", 1'b0, r[0])
    endtask
    task automatic send(input logic [7:0] p, input logic [7:0] q [$]);
        m_u.start();
        wbyte({`GVC_I2C_ADDR, 1'b0});
        wbyte(p);
        foreach (q[i]) wbyte(q[i]);
        m_u.stop();
    endtask
    task automatic fetch(input logic [7:0] p, input logic [7:0] q [$]);
        rd_q = {rd_q, q};
        m_u.start();
        wbyte({`GVC_I2C_ADDR, 1'b0});
        wbyte(p);
        m_u.start();
        wbyte({`GVC_I2C_ADDR, 1'b1});
        foreach (q[i]) m_u.rbyte(i == q.size() - 1);
        m_u.stop();
    endtask
    // Field model: each rise of the corrected vsync flips the field.
    task automatic pix(input logic [2:0] m);
        @(negedge pix_clk);
        @(negedge mclk);
        if ((vs ~^ m[1]) && !pv) fld = ~fld;
        pv = vs ~^ m[1];
        pr = 8'hfe + 8'($random(seed) & 7);
        pg = 8'hfe + 8'($random(seed) & 7);
        pb = 8'hfe + 8'($random(seed) & 7);
        {hs, vs, de} = 3'($random(seed));
        if ((vs ~^ m[1]) && !pv) fld = ~fld;
        pv = vs ~^ m[1];
        @(posedge pix_clk);
        #1 px_q.push_back({gr(pr), gr(pg), gr(pb), hs ~^ m[0], vs ~^ m[1],
                           m[2] ? fld : de});
    endtask
    task automatic ones(input int b, input int n);
        c = 0;
        repeat (n) begin
            @(posedge pix_clk);
            c += lanes[b];
        end
    endtask

    always @(m_u.got) begin
        e8 = rd_q.pop_front();
        `CHK("read byte", e8, m_u.rd_byte)
    end
    always @(posedge pix_clk) begin
        if (px_q.size() > 0) begin
            e33 = px_q.pop_front();
            `CHK("pixel", e33, {dr, dg, db, dhs, dvs, den})
        end
        if (skew_on)
            `CHK("skew lanes", {5{~ser_clk}}, lanes)
    end
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        end_sim();
    end

    initial begin
        seed = 95;
        {pr, pg, pb, hs, vs, de, align, skew_on, fld, pv} = '0;
        foreach (lut[i]) lut[i] = '0;
        repeat (5) @(negedge mclk);
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        fetch(`GVC_REG_REV, '{{5'h0, `GVC_REV_VAL}, `GVC_VM_RST, `GVC_LK_RST});
        send(`GVC_REG_REV, '{8'haa});
        m_u.start();
        m_u.xbyte({8'h30, 1'b1}, r9);
        `CHK("foreign address", 1'b1, r9[0])
        m_u.stop();
        fetch(`GVC_REG_REV, '{{5'h0, `GVC_REV_VAL}});
        fetch(8'h09, '{8'h00});
        // Entries straddle the index wrap from 8'hff back to 8'h00.
        for (int k = 0; k < 4; k++) begin
            v = 10'($random(seed));
            lut[8'hfe + 8'(k)] = v;
            d.push_back({6'h0, v[9:8]});
            d.push_back(v[7:0]);
        end
        send(`GVC_REG_LIDX, '{8'hfe});
        send(`GVC_REG_LHI, d);
        d.push_back(8'h00);
        d.push_back(8'h00);
        send(`GVC_REG_LIDX, '{8'hfe});
        fetch(`GVC_REG_LHI, d);
        for (int m = 0; m < 5; m++) begin
            send(`GVC_REG_VMODE, '{8'(m)});
            repeat (6) pix(3'(m));
        end
        send(`GVC_REG_LINK, '{8'h01});
        repeat (2) @(posedge pix_clk);
        @(negedge mclk);
        skew_on = 1'b1;
        repeat (4) @(posedge pix_clk);
        @(negedge mclk);
        skew_on = 1'b0;
        send(`GVC_REG_LINK, '{8'h02});
        align = 1'b1;
        ones(2, 2);
        ones(2, 8);
        `CHK("align ones", 4, c)
        send(`GVC_REG_LINK, '{8'h04});
        ones(4, 2);
        ones(4, 16);
        `CHK("prbs mixed", 1'b1, c > 0 && c < 16)
        end_sim();
    end
endmodule
